// file: alp_add8.sv
// 8-bit adder with carry in, carry out of bit 7 and of bit 3
// assumes purely combinational use inside the datapath
`timescale 1ns/1ns
module alp_add8 (
    input wire logic [7:0] a_in,
    input wire logic [7:0] b_in,
    input wire logic cin_in,
    output logic [7:0] sum_out,
    output logic c7_out,
    output logic c3_out
);
    logic [4:0] lo_sum;
    logic [4:0] hi_sum;

    // low nibble first so the nibble carry is visible
    assign lo_sum = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin_in};
    assign hi_sum = {1'b0, a_in[7:4]} + {1'b0, b_in[7:4]} + {4'h0, lo_sum[4]};
    assign sum_out = {hi_sum[3:0], lo_sum[3:0]};
    assign c7_out = hi_sum[4];
    assign c3_out = lo_sum[4];
endmodule : alp_add8

// file: alp_core.sv
// datapath for pointer add, and/add with immediate or file, shift and bit clear
// assumes an apb master on the register port and a file register store that
// takes results from the file write strobe
`timescale 1ns/1ns
// Summary of operation
// - pointer add: sign-extended 6-bit literal, flags kept
// - pointer result wraps modulo 65536
// - and immediate into working register, zero only
// - add immediate into working register, c dc z
// - add file register, destination bit routes result
// - and file register, routed, zero only
// - arithmetic shift right, old bit0 to carry
// - add with carry, routed, c dc z
// - clear one indexed bit, flags kept
// - every operation completes in one cycle
module alp_core
    import alp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic [6:0] FILE_ADDR_OUT,
    output logic [7:0] FILE_DATA_OUT,
    output logic FILE_WE_OUT,
    output logic OP_DONE_OUT
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic is_zero(input logic [7:0] v);
        return (v == 8'h00);
    endfunction : is_zero

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return (a == ADDR_W'(ofs));
    endfunction : hit

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] w_ff;
    logic [2:0] status_ff;
    logic [7:0] fopnd_ff;
    logic [15:0] ptr0_ff;
    logic [15:0] ptr1_ff;
    logic [7:0] fres_ff;
    logic [31:0] cmd_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [6:0] faddr_ff;
    logic [7:0] fdata_ff;
    logic fwe_ff;
    logic done_ff;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire apb_setup = PSEL_IN & ~PENABLE_IN;
    wire apb_done = PSEL_IN & PENABLE_IN & pready_ff;
    wire wr_done = apb_done & PWRITE_IN;
    wire hit_cmd = hit(PADDR_IN, OFS_CMD);
    wire hit_wreg = hit(PADDR_IN, OFS_WREG);
    wire hit_status = hit(PADDR_IN, OFS_STATUS);
    wire hit_fopnd = hit(PADDR_IN, OFS_FOPND);
    wire hit_ptr0 = hit(PADDR_IN, OFS_PTR0);
    wire hit_ptr1 = hit(PADDR_IN, OFS_PTR1);
    wire hit_fres = hit(PADDR_IN, OFS_FRES);
    wire hit_any = hit_cmd | hit_wreg | hit_status | hit_fopnd | hit_ptr0 | hit_ptr1
                   | hit_fres;
    wire bad_acc = ~hit_any | (hit_fres & PWRITE_IN); // result register is read only

    // read data mux, sampled in the setup cycle
    wire [31:0] rd_mux = hit_cmd ? cmd_ff :
                         hit_wreg ? {24'h0, w_ff} :
                         hit_status ? {29'h0, status_ff} :
                         hit_fopnd ? {24'h0, fopnd_ff} :
                         hit_ptr0 ? {16'h0, ptr0_ff} :
                         hit_ptr1 ? {16'h0, ptr1_ff} :
                         hit_fres ? {24'h0, fres_ff} : 32'h0000_0000;

    // ------------------------------------------------------------
    // command fields and operation decode
    // ------------------------------------------------------------
    wire exec = wr_done & hit_cmd;
    wire [3:0] op = PWDATA_IN[CMD_OP_LSB +: CMD_OP_W];
    wire dest_f = PWDATA_IN[CMD_DEST_BIT];
    wire ptr_sel = PWDATA_IN[CMD_PSEL_BIT];
    wire [2:0] bidx = PWDATA_IN[CMD_BIDX_LSB +: 3];
    wire [6:0] faddr = PWDATA_IN[CMD_FADDR_LSB +: 7];
    wire [7:0] lit = PWDATA_IN[CMD_LIT_LSB +: 8];
    wire op_ptr = (op == OP_PTR_ADD);
    wire op_andi = (op == OP_AND_IMM);
    wire op_addi = (op == OP_ADD_IMM);
    wire op_addf = (op == OP_ADD_FILE);
    wire op_andf = (op == OP_AND_FILE);
    wire op_asr = (op == OP_ASR_FILE);
    wire op_addc = (op == OP_ADDC_FILE);
    wire op_bclr = (op == OP_BIT_CLR);
    wire op_arith = op_addi | op_addf | op_addc;
    wire op_routed = op_addf | op_andf | op_asr | op_addc;

    // ------------------------------------------------------------
    // byte datapath
    // ------------------------------------------------------------
    logic [7:0] add_sum;
    logic add_c7;
    logic add_c3;

    // adder operand is the literal or the file operand; carry only for add with carry
    alp_add8 u_add (
        .a_in(w_ff),
        .b_in(op_addi ? lit : fopnd_ff),
        .cin_in(op_addc & status_ff[ST_C_BIT]),
        .sum_out(add_sum),
        .c7_out(add_c7),
        .c3_out(add_c3)
    );

    wire [7:0] and_res = w_ff & (op_andi ? lit : fopnd_ff);
    wire [7:0] asr_res = {fopnd_ff[7], fopnd_ff[7:1]};
    wire [7:0] bclr_res = fopnd_ff & ~(8'h01 << bidx);
    wire [7:0] res8 = op_arith ? add_sum :
                      (op_andi | op_andf) ? and_res :
                      op_asr ? asr_res : bclr_res;

    // destination: immediates go to w, bit clear to file, others by dest bit
    wire to_w = op_andi | op_addi | (op_routed & ~dest_f);
    wire to_file = (op_routed & dest_f) | op_bclr;

    // flag updates; pointer add and bit clear touch none
    wire upd_z = op_andi | op_andf | op_arith | op_asr;
    wire upd_c = op_arith | op_asr;
    wire upd_dc = op_arith;
    wire new_c = op_arith ? add_c7 : fopnd_ff[0];
    wire new_z = is_zero(res8);

    // pointer path: sign extend the 6-bit literal, 16-bit sum wraps
    wire [15:0] sext = {{10{lit[5]}}, lit[5:0]};
    wire [15:0] ptr_src = ptr_sel ? ptr1_ff : ptr0_ff;
    wire [15:0] ptr_sum = 16'(ptr_src + sext);

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    wire wr_reg = wr_done & ~exec;
    wire [7:0] nxt_w_ff = (exec & to_w) ? res8 :
                          (wr_reg & hit_wreg) ? PWDATA_IN[7:0] : w_ff;
    wire sw_st = wr_reg & hit_status;
    wire nxt_c = (exec & upd_c) ? new_c :
                 sw_st ? PWDATA_IN[ST_C_BIT] : status_ff[ST_C_BIT];
    wire nxt_dc = (exec & upd_dc) ? add_c3 :
                  sw_st ? PWDATA_IN[ST_DC_BIT] : status_ff[ST_DC_BIT];
    wire nxt_z = (exec & upd_z) ? new_z :
                 sw_st ? PWDATA_IN[ST_Z_BIT] : status_ff[ST_Z_BIT];
    wire [2:0] nxt_status_ff = {nxt_z, nxt_dc, nxt_c};
    wire [15:0] nxt_ptr0_ff = (exec & op_ptr & ~ptr_sel) ? ptr_sum :
                              (wr_reg & hit_ptr0) ? PWDATA_IN[15:0] : ptr0_ff;
    wire [15:0] nxt_ptr1_ff = (exec & op_ptr & ptr_sel) ? ptr_sum :
                              (wr_reg & hit_ptr1) ? PWDATA_IN[15:0] : ptr1_ff;
    wire [7:0] nxt_fopnd_ff = (wr_reg & hit_fopnd) ? PWDATA_IN[7:0] : fopnd_ff;

    // ------------------------------------------------------------
    // apb answer registers: one wait-free access phase
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= apb_setup;
            pslverr_ff <= apb_setup & bad_acc;
            prdata_ff <= (apb_setup & ~PWRITE_IN) ? rd_mux : 32'h0000_0000;
        end
    end

    // architectural state
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            w_ff <= RST_WREG;
            status_ff <= RST_STATUS;
            fopnd_ff <= RST_WREG;
            ptr0_ff <= RST_PTR;
            ptr1_ff <= RST_PTR;
        end else begin
            w_ff <= nxt_w_ff;
            status_ff <= nxt_status_ff;
            fopnd_ff <= nxt_fopnd_ff;
            ptr0_ff <= nxt_ptr0_ff;
            ptr1_ff <= nxt_ptr1_ff;
        end
    end

    // command echo, file write strobe and completion pulse
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            cmd_ff <= RST_CMD;
            fres_ff <= RST_WREG;
            faddr_ff <= 7'h00;
            fdata_ff <= 8'h00;
            fwe_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            fwe_ff <= exec & to_file;
            done_ff <= exec;
            if (exec) begin
                cmd_ff <= PWDATA_IN;
            end
            if (exec & to_file) begin
                fres_ff <= res8;
                faddr_ff <= faddr;
                fdata_ff <= res8;
            end
        end
    end

    assign PRDATA_OUT = prdata_ff;
    assign PREADY_OUT = pready_ff;
    assign PSLVERR_OUT = pslverr_ff;
    assign FILE_ADDR_OUT = faddr_ff;
    assign FILE_DATA_OUT = fdata_ff;
    assign FILE_WE_OUT = fwe_ff;
    assign OP_DONE_OUT = done_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    sequence s_op(logic [3:0] code);
        exec && (op == code);
    endsequence

    // completion pulse stands for exactly one cycle
    sequence s_done_pulse;
        OP_DONE_OUT ##1 !OP_DONE_OUT;
    endsequence

    // pointer path
    a_ptr_flags_kept: assert property (s_op(OP_PTR_ADD) |=> $stable(status_ff))
        else $error("pointer add changed a flag");
    a_ptr_wrap_sum: assert property (s_op(OP_PTR_ADD) ##0 !ptr_sel |=>
        ptr0_ff == 16'($past(ptr0_ff) + {{10{$past(lit[5])}}, $past(lit[5:0])}))
        else $error("pointer 0 sum wrong");
    a_ptr1_sum: assert property (s_op(OP_PTR_ADD) ##0 ptr_sel |=>
        ptr1_ff == 16'($past(ptr1_ff) + {{10{$past(lit[5])}}, $past(lit[5:0])})
        && $stable(ptr0_ff))
        else $error("pointer 1 sum wrong");

    // byte operations
    a_andi_result: assert property (s_op(OP_AND_IMM) |=>
        w_ff == ($past(w_ff) & $past(lit)) && status_ff[1:0] == $past(status_ff[1:0]))
        else $error("and immediate result or flags wrong");
    a_addi_carry: assert property (s_op(OP_ADD_IMM) |=>
        {status_ff[ST_C_BIT], w_ff} == {1'b0, $past(w_ff)} + {1'b0, $past(lit)})
        else $error("add immediate sum or carry wrong");
    a_imm_no_file: assert property (exec && (op_andi || op_addi) |=> !FILE_WE_OUT)
        else $error("immediate result strobed to file");
    a_addf_route: assert property (s_op(OP_ADD_FILE) ##0 dest_f |=>
        FILE_WE_OUT && $stable(w_ff) ##1 !FILE_WE_OUT)
        else $error("add file to file misrouted");
    a_addf_addr: assert property (s_op(OP_ADD_FILE) ##0 dest_f |=>
        FILE_ADDR_OUT == $past(faddr))
        else $error("add file to file wrong address");
    a_andf_w: assert property (s_op(OP_AND_FILE) ##0 !dest_f |=>
        w_ff == ($past(w_ff) & $past(fopnd_ff)) && !FILE_WE_OUT)
        else $error("and file to w wrong");
    a_asr_shift: assert property (s_op(OP_ASR_FILE) |=>
        status_ff[ST_C_BIT] == $past(fopnd_ff[0])
        && status_ff[ST_DC_BIT] == $past(status_ff[ST_DC_BIT]))
        else $error("shift carry wrong");
    a_asr_w: assert property (s_op(OP_ASR_FILE) ##0 !dest_f |=>
        w_ff == {$past(fopnd_ff[7]), $past(fopnd_ff[7:1])})
        else $error("shift result wrong");
    a_addc_sum: assert property (s_op(OP_ADDC_FILE) ##0 !dest_f |=>
        w_ff == 8'($past(w_ff) + $past(fopnd_ff) + {7'h0, $past(status_ff[ST_C_BIT])}))
        else $error("add with carry wrong");
    a_addc_file: assert property (s_op(OP_ADDC_FILE) ##0 dest_f |=>
        FILE_DATA_OUT == 8'($past(w_ff) + $past(fopnd_ff) + {7'h0, $past(status_ff[ST_C_BIT])})
        && $stable(w_ff))
        else $error("add with carry to file wrong");
    a_bclr_bit: assert property (s_op(OP_BIT_CLR) |=>
        FILE_DATA_OUT[$past(bidx)] == 1'b0 && $stable(status_ff)
        && (FILE_DATA_OUT | (8'h01 << $past(bidx)))
        == ($past(fopnd_ff) | (8'h01 << $past(bidx))))
        else $error("bit clear wrong");

    // timing and flags
    a_one_cycle: assert property (exec |=> s_done_pulse)
        else $error("operation not done in one cycle");
    a_zero_flag: assert property (s_op(OP_ADD_FILE) |=>
        status_ff[ST_Z_BIT] == ($past(add_sum) == 8'h00)
        && status_ff[ST_DC_BIT] == $past(add_c3))
        else $error("zero or nibble carry wrong");
endmodule : alp_core

// file: alp_file_model.sv
// file register store standing on the datapath's result strobe
// assumes results arrive as a one-cycle write strobe on the core clock
`timescale 1ns/1ns
module alp_file_model (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [6:0] addr_in,
    input wire logic [7:0] data_in,
    input wire logic we_in
);
    logic [7:0] mem_ff [128];
    int wr_cnt_ff;
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // take a result only on its strobe, never from a held data bus
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem_ff[addr_in] <= data_in;
        end
    end
    // count strobes so a stray write shows up
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_cnt_ff <= 0;
        end else if (we_in) begin
            wr_cnt_ff <= wr_cnt_ff + 1;
        end
    end
endmodule : alp_file_model

// file: alp_pkg.sv
// package for the arithmetic, logic and pointer datapath
// assumes a single 50 MHz clock and an apb register port with 32-bit data
package alp_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_WREG = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_FOPND = 8'h0c;
    localparam logic [7:0] OFS_PTR0 = 8'h10;
    localparam logic [7:0] OFS_PTR1 = 8'h14;
    localparam logic [7:0] OFS_FRES = 8'h18;

    // ------------------------------------------------------------
    // command word field positions
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_W = 4;
    localparam int CMD_DEST_BIT = 4;
    localparam int CMD_PSEL_BIT = 5;
    localparam int CMD_BIDX_LSB = 6;
    localparam int CMD_FADDR_LSB = 9;
    localparam int CMD_LIT_LSB = 16;

    // status bit positions
    localparam int ST_C_BIT = 0;
    localparam int ST_DC_BIT = 1;
    localparam int ST_Z_BIT = 2;

    // ------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_PTR_ADD = 4'h1;
    localparam logic [3:0] OP_AND_IMM = 4'h2;
    localparam logic [3:0] OP_ADD_IMM = 4'h3;
    localparam logic [3:0] OP_ADD_FILE = 4'h4;
    localparam logic [3:0] OP_AND_FILE = 4'h5;
    localparam logic [3:0] OP_ASR_FILE = 4'h6;
    localparam logic [3:0] OP_ADDC_FILE = 4'h7;
    localparam logic [3:0] OP_BIT_CLR = 4'h8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_WREG = 8'h00;
    localparam logic [2:0] RST_STATUS = 3'h0;
    localparam logic [15:0] RST_PTR = 16'h0000;
    localparam logic [31:0] RST_CMD = 32'h0000_0000;
endpackage : alp_pkg

// file: tb_alp_core.sv
// self-checking bench for the arithmetic, logic and pointer datapath
// assumes an apb slave that answers with pready and a file store on the strobe
`timescale 1ns/1ns
module tb_alp_core;
    import alp_pkg::*;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, file_we, op_done, er;
    logic [7:0] paddr, file_data;
    logic [6:0] file_addr;
    logic [31:0] pwdata, prdata, rd;
    int err_count = 0;
    int cmp_count = 0;

    alp_core dut (.CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .FILE_ADDR_OUT(file_addr),
        .FILE_DATA_OUT(file_data), .FILE_WE_OUT(file_we), .OP_DONE_OUT(op_done));
    alp_file_model fm (.clk_in(clk), .rst_b_in(rst_b), .addr_in(file_addr),
        .data_in(file_data), .we_in(file_we));

    // ------------------------------------------------------------
    // clock, compare and closing
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: value %h, expected %h", $time, got, exp);
        end
    endtask : chk_w
    task automatic chk_b(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : chk_b
    task automatic test_done;
        $display("compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // bus and command helpers
    // ------------------------------------------------------------
    // one apb transfer; pready and the answer are taken at the rising edge,
    // and the request is released only after that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_w(rd, exp);
        chk_b(er, 1'b0);
    endtask : rdc
    function automatic logic [31:0] mk(input logic [3:0] op, input logic d, input logic n,
        input logic [2:0] b, input logic [6:0] f, input logic [7:0] k);
        return {8'h00, k, f, b, n, d, op};
    endfunction : mk
    // launch a command, then see the done pulse last exactly one cycle
    task automatic exec(input logic [31:0] c, input logic fw);
        apb(1'b1, OFS_CMD, c);
        @(negedge clk);
        chk_b(op_done, 1'b1);
        chk_b(file_we, fw);
        @(negedge clk);
        chk_b(op_done, 1'b0);
    endtask : exec
    task automatic setup(input logic [7:0] w, input logic [2:0] st, input logic [7:0] fop);
        apb(1'b1, OFS_WREG, {24'h0, w});
        apb(1'b1, OFS_STATUS, {29'h0, st});
        apb(1'b1, OFS_FOPND, {24'h0, fop});
    endtask : setup
    task automatic res(input logic [7:0] w, input logic [2:0] st);
        rdc(OFS_WREG, {24'h0, w});
        rdc(OFS_STATUS, {29'h0, st});
    endtask : res
    task automatic fchk(input logic [6:0] f, input logic [7:0] v);
        chk_w({24'h0, fm.mem_ff[f]}, {24'h0, v});
        rdc(OFS_FRES, {24'h0, v});
    endtask : fchk

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 7; i++) rdc(8'(4 * i), 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk_b(er, 1'b1);
        chk_w(rd, 32'h0);
        apb(1'b1, OFS_FRES, 32'h5a);
        chk_b(er, 1'b1);
        rdc(OFS_FRES, 32'h0);
        exec(mk(4'hf, 1'b1, 1'b0, 3'h0, 7'h01, 8'h00), 1'b0);
        rdc(OFS_CMD, 32'h0000_021f);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_ptr;
        apb(1'b1, OFS_PTR0, 32'hffff_ffff);
        rdc(OFS_PTR0, 32'h0000_ffff);
        apb(1'b1, OFS_STATUS, 32'h7);
        exec(mk(OP_PTR_ADD, 1'b0, 1'b0, 3'h0, 7'h0, 8'h01), 1'b0);
        rdc(OFS_PTR0, 32'h0);
        exec(mk(OP_PTR_ADD, 1'b0, 1'b1, 3'h0, 7'h0, 8'he0), 1'b0);
        rdc(OFS_PTR1, 32'h0000_ffe0);
        exec(mk(OP_PTR_ADD, 1'b0, 1'b1, 3'h0, 7'h0, 8'h1f), 1'b0);
        rdc(OFS_PTR1, 32'h0000_ffff);
        rdc(OFS_PTR0, 32'h0);
        rdc(OFS_STATUS, 32'h7);
        $display("t_ptr done");
    endtask : t_ptr
    task automatic t_and;
        setup(8'hf0, 3'h3, 8'h3c);
        exec(mk(OP_AND_IMM, 1'b0, 1'b0, 3'h0, 7'h0, 8'h0f), 1'b0);
        res(8'h00, 3'h7);
        setup(8'h35, 3'h7, 8'h3c);
        exec(mk(OP_AND_FILE, 1'b1, 1'b0, 3'h0, 7'h55, 8'h00), 1'b1);
        res(8'h35, 3'h3);
        fchk(7'h55, 8'h34);
        exec(mk(OP_AND_FILE, 1'b0, 1'b0, 3'h0, 7'h55, 8'h00), 1'b0);
        res(8'h34, 3'h3);
        $display("t_and done");
    endtask : t_and
    task automatic t_add;
        setup(8'h88, 3'h0, 8'h00);
        exec(mk(OP_ADD_IMM, 1'b0, 1'b0, 3'h0, 7'h0, 8'h78), 1'b0);
        res(8'h00, 3'h7);
        setup(8'h01, 3'h7, 8'h0e);
        exec(mk(OP_ADD_FILE, 1'b0, 1'b0, 3'h0, 7'h10, 8'h00), 1'b0);
        res(8'h0f, 3'h0);
        setup(8'h0f, 3'h0, 8'h01);
        exec(mk(OP_ADD_FILE, 1'b1, 1'b0, 3'h0, 7'h7f, 8'h00), 1'b1);
        res(8'h0f, 3'h2);
        fchk(7'h7f, 8'h10);
        $display("t_add done");
    endtask : t_add
    task automatic t_addc;
        setup(8'hff, 3'h1, 8'h00);
        exec(mk(OP_ADDC_FILE, 1'b0, 1'b0, 3'h0, 7'h01, 8'h00), 1'b0);
        res(8'h00, 3'h7);
        setup(8'h7f, 3'h0, 8'h80);
        exec(mk(OP_ADDC_FILE, 1'b1, 1'b0, 3'h0, 7'h02, 8'h00), 1'b1);
        res(8'h7f, 3'h0);
        fchk(7'h02, 8'hff);
        $display("t_addc done");
    endtask : t_addc
    task automatic t_asr;
        setup(8'h11, 3'h2, 8'h81);
        exec(mk(OP_ASR_FILE, 1'b0, 1'b0, 3'h0, 7'h03, 8'h00), 1'b0);
        res(8'hc0, 3'h3);
        setup(8'h11, 3'h2, 8'h01);
        exec(mk(OP_ASR_FILE, 1'b1, 1'b0, 3'h0, 7'h03, 8'h00), 1'b1);
        res(8'h11, 3'h7);
        fchk(7'h03, 8'h00);
        $display("t_asr done");
    endtask : t_asr
    task automatic t_bclr;
        for (int b = 0; b < 8; b++) begin
            setup(8'h00, 3'h5, 8'hff);
            exec(mk(OP_BIT_CLR, 1'b1, 1'b0, 3'(b), 7'(b + 8), 8'h00), 1'b1);
            fchk(7'(b + 8), ~(8'h01 << b));
            res(8'h00, 3'h5);
        end
        chk_w(32'(fm.wr_cnt_ff), 32'h0000_000c);
        $display("t_bclr done");
    endtask : t_bclr

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_ptr;
        t_and;
        t_add;
        t_addc;
        t_asr;
        t_bclr;
        test_done;
    end
    initial begin
        #200000;
        err_count++;
        test_done;
    end
endmodule : tb_alp_core
